/* src/csf_clock_startup_failsafe.sv */
// clock source sequencer: start-up timer, two-speed start-up, fail-safe monitor, registers
// assumes oscillator levels and config straps are synchronous samples taken on clk
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "csf_consts.svh"

module csf_clock_startup_failsafe (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	input wire logic extClkIn,
	input wire logic intOscIn,
	input wire logic lfOscIn,
	input wire logic [2:0] oscModeCfg,
	input wire logic twoSpeedCfg,
	input wire logic failMonCfg,
	input wire logic powerupTimerCfg,
	input wire logic powerupTimerDone,
	input wire logic sleepExec,
	input wire logic wakeEvent,
	output logic sysClkExternal,
	output logic sysClkHoldLow,
	output logic execHold,
	output logic startupTimeout,
	output logic failSafeActive,
	output logic oscFailIrq,
	output logic [2:0] intFreqSelect,
	output logic [4:0] oscTuning
);

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// crystal modes are the only ones that need a stabilisation wait
	function automatic logic isCrystal(input logic [2:0] mode);
		isCrystal = (mode == `CSF_MODE_LP) || (mode == `CSF_MODE_XT) ||
			(mode == `CSF_MODE_HS);
	endfunction

	function automatic logic isInternalMode(input logic [2:0] mode);
		isInternalMode = (mode == `CSF_MODE_INTIO) || (mode == `CSF_MODE_INT);
	endfunction

	// where a fresh start goes, from configuration and clock select
	function automatic csf_pkg::csf_state_e startRoute(input logic [2:0] mode,
		input logic selInternal);
		if (selInternal || isInternalMode(mode)) begin
			startRoute = csf_pkg::CSF_INTERNAL;
		end else if (isCrystal(mode)) begin
			startRoute = csf_pkg::CSF_STARTUP;
		end else begin
			startRoute = csf_pkg::CSF_EXTERNAL;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state

	csf_pkg::csf_state_e state;
	csf_pkg::csf_state_e next_state;
	logic clkSelect;
	logic [2:0] freqSelect;
	logic [4:0] tuneValue;
	logic [7:0] irqEnable;
	logic [7:0] irqFlags;
	logic failSafe;
	logic timeoutStatus;
	logic extPrev;
	logic intPrev;
	logic lfPrev;
	logic [5:0] lfCount;
	logic seenLow;
	logic [10:0] ostCount;
	logic resetSeen;

	////////////////////////////////////////////////////////////////////////////////
	// edges and bus decode

	wire extFall = extPrev & ~extClkIn;
	wire intFall = intPrev & ~intOscIn;
	wire lfRise = ~lfPrev & lfOscIn;
	wire wrOsc = wrStrobe && (addr == `CSF_REG_OSC_CONTROL);
	wire wrTune = wrStrobe && (addr == `CSF_REG_OSC_TUNING);
	wire wrIrqEn = wrStrobe && (addr == `CSF_REG_IRQ_ENABLE_TWO);
	wire wrIrqFlag = wrStrobe && (addr == `CSF_REG_IRQ_FLAGS_TWO);
	wire newSelect = wrData[`CSF_OSC_CLKSEL_BIT];
	wire selToggle = wrOsc && (newSelect != clkSelect);

	////////////////////////////////////////////////////////////////////////////////
	// fail detector on the divided sample clock

	// divide by 64: high half when the counter's top bit is set
	wire sampleRise = lfRise && (lfCount == `CSF_SAMPLE_RISE_AT);
	wire sampleFall = lfRise && (lfCount == `CSF_SAMPLE_FALL_AT);
	// only watching once the external clock is the live source
	wire monitorActive = failMonCfg && (state == csf_pkg::CSF_EXTERNAL);
	// latch still clear at the end of a sample half-period means no low edge came
	wire oscFail = monitorActive && sampleFall && ~seenLow;

	////////////////////////////////////////////////////////////////////////////////
	// start-up timer and two-speed qualification

	// fail monitor forces two-speed so code always runs while the timer counts
	wire twoSpeedActive = (twoSpeedCfg || failMonCfg) && ~clkSelect &&
		isCrystal(oscModeCfg);
	wire ostDone = (state == csf_pkg::CSF_STARTUP) && extFall &&
		(ostCount == (`CSF_OST_CYCLES - 11'h001));
	// judged on the coming state so the hold lines up with the other clock outputs
	wire inStartup = (next_state == csf_pkg::CSF_STARTUP) ||
		(next_state == csf_pkg::CSF_INT_EDGE) || (next_state == csf_pkg::CSF_HOLD_LOW);
	// power-up wait lasts two clocks after reset when its timer is not enabled
	wire pwrtSkip = (state == csf_pkg::CSF_POWERUP_TIMER_WAIT) && resetSeen && ~powerupTimerCfg;
	// fail-safe restart keeps executing on the internal clock, as two-speed does
	wire next_execHold = inStartup && ~twoSpeedActive && ~failSafe;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	// sleep beats everything, then a clock-select toggle, then the normal flow
	always_comb begin
		next_state = state;
		unique case (state)
			csf_pkg::CSF_POWERUP_TIMER_WAIT: begin
				if (powerupTimerDone || pwrtSkip) begin
					next_state = startRoute(oscModeCfg, clkSelect);
				end
			end
			csf_pkg::CSF_STARTUP: begin
				if (ostDone) begin
					next_state = csf_pkg::CSF_INT_EDGE;
				end
			end
			csf_pkg::CSF_INT_EDGE: begin
				if (intFall) begin
					next_state = csf_pkg::CSF_HOLD_LOW;
				end
			end
			csf_pkg::CSF_HOLD_LOW: begin
				if (extFall) begin
					next_state = csf_pkg::CSF_EXTERNAL;
				end
			end
			csf_pkg::CSF_EXTERNAL: begin
				if (oscFail) begin
					next_state = csf_pkg::CSF_INTERNAL;
				end
			end
			csf_pkg::CSF_INTERNAL: begin
				next_state = csf_pkg::CSF_INTERNAL;
			end
			csf_pkg::CSF_SLEEP: begin
				if (wakeEvent) begin
					next_state = startRoute(oscModeCfg, clkSelect);
				end
			end
		endcase
		if (sleepExec) begin
			next_state = csf_pkg::CSF_SLEEP;
		end else if (selToggle) begin
			// a toggle in fail-safe routes as for clock select 0, so only crystal modes re-run the external start-up
			next_state = failSafe ? startRoute(oscModeCfg, 1'b0) :
				startRoute(oscModeCfg, newSelect);
		end
	end

	// timeout status follows the external clock taking charge, from the hold-low gap on
	wire next_timeout = (next_state == csf_pkg::CSF_HOLD_LOW) ||
		(next_state == csf_pkg::CSF_EXTERNAL);

	// set on failure; cleared by sleep or when the external clock is back
	wire failSafeClear = sleepExec || ostDone ||
		(failSafe && selToggle && (next_state == csf_pkg::CSF_EXTERNAL));
	// sleep outranks a failure caught in the same cycle, as it does for the state
	wire next_failSafe = (oscFail && ~sleepExec) || (failSafe && ~failSafeClear);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= csf_pkg::CSF_POWERUP_TIMER_WAIT;
		end else begin
			state <= next_state;
		end
	end

	// marks the first clock after reset for the power-up wait
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resetSeen <= 1'b0;
		end else begin
			resetSeen <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// edge history, sample divider, detector latch, start-up counter

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			extPrev <= 1'b0;
			intPrev <= 1'b0;
			lfPrev <= 1'b0;
		end else begin
			extPrev <= extClkIn;
			intPrev <= intOscIn;
			lfPrev <= lfOscIn;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfCount <= 6'h00;
		end else if (lfRise) begin
			lfCount <= lfCount + 6'h01;
		end
	end

	// an external low edge in the clearing cycle still counts, so set wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seenLow <= 1'b0;
		end else if (extFall) begin
			seenLow <= 1'b1;
		end else if (sampleRise) begin
			seenLow <= 1'b0;
		end
	end

	// counts external falling edges; restarts whenever start-up is left
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ostCount <= 11'h000;
		end else if (state != csf_pkg::CSF_STARTUP || next_state != csf_pkg::CSF_STARTUP) begin
			ostCount <= 11'h000;
		end else if (extFall) begin
			ostCount <= ostCount + 11'h001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			failSafe <= 1'b0;
			timeoutStatus <= 1'b0;
		end else begin
			failSafe <= next_failSafe;
			timeoutStatus <= next_timeout;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software registers

	// automatic switches leave clock select untouched; only software writes it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clkSelect <= 1'b0;
			freqSelect <= `CSF_FREQ_RESET;
		end else if (wrOsc) begin
			clkSelect <= newSelect;
			freqSelect <= wrData[`CSF_OSC_FREQ_MSB:`CSF_OSC_FREQ_LSB];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tuneValue <= `CSF_TUNE_RESET;
			irqEnable <= `CSF_BYTE_RESET;
		end else begin
			if (wrTune) begin
				tuneValue <= wrData[4:0];
			end
			if (wrIrqEn) begin
				irqEnable <= wrData & `CSF_IRQ_IMPL_MASK;
			end
		end
	end

	// fail flag: a write of zero is refused while fail-safe stands; hardware set wins
	wire flagKeep = irqFlags[`CSF_IRQ_OSCFAIL_BIT] && failSafe;
	wire next_failFlag = oscFail ||
		(wrIrqFlag ? (wrData[`CSF_IRQ_OSCFAIL_BIT] || flagKeep) :
		irqFlags[`CSF_IRQ_OSCFAIL_BIT]);
	wire [7:0] flagOthers = wrIrqFlag ? (wrData & `CSF_IRQ_IMPL_MASK) : irqFlags;
	wire [7:0] failBit = 8'h01 << `CSF_IRQ_OSCFAIL_BIT;
	wire [7:0] next_irqFlags = (flagOthers & ~failBit) | (next_failFlag ? failBit : 8'h00);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqFlags <= `CSF_BYTE_RESET;
		end else begin
			irqFlags <= next_irqFlags;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path

	wire hfStable = (freqSelect != 3'h0);
	wire lfStable = (freqSelect == 3'h0) || failMonCfg || powerupTimerCfg;
	wire [7:0] oscControlRead = {1'b0, freqSelect, timeoutStatus, hfStable, lfStable, clkSelect};
	wire [7:0] configRead = {failMonCfg, twoSpeedCfg, 1'b0, powerupTimerCfg, 1'b0, oscModeCfg};
	logic [7:0] readMux;

	// unmapped offsets read as zero
	always_comb begin
		readMux = 8'h00;
		unique case (addr)
			`CSF_REG_OSC_CONTROL: readMux = oscControlRead;
			`CSF_REG_OSC_TUNING: readMux = {3'h0, tuneValue};
			`CSF_REG_IRQ_ENABLE_TWO: readMux = irqEnable;
			`CSF_REG_IRQ_FLAGS_TWO: readMux = irqFlags;
			`CSF_REG_CONFIG_WORD: readMux = configRead;
			default: readMux = 8'h00;
		endcase
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData <= 8'h00;
		end else begin
			rdData <= rdStrobe ? readMux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs

	// enable taken as it will stand, so a write of the enable shows at once
	wire next_irqEnable = wrIrqEn ? wrData[`CSF_IRQ_OSCFAIL_BIT] :
		irqEnable[`CSF_IRQ_OSCFAIL_BIT];
	wire next_irq = next_irqFlags[`CSF_IRQ_OSCFAIL_BIT] && next_irqEnable;

	// internal clock runs whenever neither external nor held low, at the selected frequency
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sysClkExternal <= 1'b0;
			sysClkHoldLow <= 1'b0;
			execHold <= 1'b0;
			startupTimeout <= 1'b0;
			failSafeActive <= 1'b0;
			oscFailIrq <= 1'b0;
			intFreqSelect <= `CSF_FREQ_RESET;
			oscTuning <= `CSF_TUNE_RESET;
		end else begin
			sysClkExternal <= (next_state == csf_pkg::CSF_EXTERNAL);
			sysClkHoldLow <= (next_state == csf_pkg::CSF_HOLD_LOW);
			execHold <= next_execHold || (next_state == csf_pkg::CSF_POWERUP_TIMER_WAIT);
			startupTimeout <= next_timeout;
			failSafeActive <= next_failSafe;
			oscFailIrq <= next_irq;
			intFreqSelect <= wrOsc ? wrData[`CSF_OSC_FREQ_MSB:`CSF_OSC_FREQ_LSB] :
				freqSelect;
			oscTuning <= wrTune ? wrData[4:0] : tuneValue;
		end
	end

endmodule // csf_clock_startup_failsafe

/* common/csf_consts.svh */
// offsets, field positions, reset values and counts of the clock start-up / fail-safe block
// assumes inclusion by bare name from the design file
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH

// register offsets on the plain register port
`define CSF_REG_OSC_CONTROL 3'h0
`define CSF_REG_OSC_TUNING 3'h1
`define CSF_REG_IRQ_ENABLE_TWO 3'h2
`define CSF_REG_IRQ_FLAGS_TWO 3'h3
`define CSF_REG_CONFIG_WORD 3'h4

// oscillator_control fields
`define CSF_OSC_FREQ_LSB 4
`define CSF_OSC_FREQ_MSB 6
`define CSF_OSC_TIMEOUT_BIT 3
`define CSF_OSC_HF_STABLE_BIT 2
`define CSF_OSC_LF_STABLE_BIT 1
`define CSF_OSC_CLKSEL_BIT 0

// irq enable / flag fields
`define CSF_IRQ_OSCFAIL_BIT 7
`define CSF_IRQ_IMPL_MASK 8'hF5

// configuration word readback fields
`define CSF_CFG_FAILMON_BIT 7
`define CSF_CFG_TWOSPEED_BIT 6
`define CSF_CFG_POWERUP_TIMER_BIT 4

// reset values
`define CSF_FREQ_RESET 3'h6
`define CSF_TUNE_RESET 5'h00
`define CSF_BYTE_RESET 8'h00

// oscillator configuration codes
`define CSF_MODE_LP 3'h0
`define CSF_MODE_XT 3'h1
`define CSF_MODE_HS 3'h2
`define CSF_MODE_EC 3'h3
`define CSF_MODE_INTIO 3'h4
`define CSF_MODE_INT 3'h5
`define CSF_MODE_RESISTOR_CAP_IO_MODE 3'h6
`define CSF_MODE_RC 3'h7

// start-up timer length in external oscillations
`define CSF_OST_CYCLES 11'h400
// sample clock is the low-frequency oscillator divided by 64 (6-bit counter)
`define CSF_SAMPLE_RISE_AT 6'h1F
`define CSF_SAMPLE_FALL_AT 6'h3F

`endif

/* common/csf_pkg.sv */
// types of the clock start-up / fail-safe block
// assumes nothing beyond a SystemVerilog compiler
package csf_pkg;

	// clock sequencing states
	typedef enum logic [2:0] {
		CSF_POWERUP_TIMER_WAIT,
		CSF_STARTUP,
		CSF_INT_EDGE,
		CSF_HOLD_LOW,
		CSF_EXTERNAL,
		CSF_INTERNAL,
		CSF_SLEEP
	} csf_state_e;

endpackage

/* verification/csf_clock_startup_failsafe_asserts.sv */
// temporal checks on the ports of the clock start-up / fail-safe block
// assumes one clk domain and a bind onto the top module
`timescale 1ns/10ps
module csf_clock_startup_failsafe_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic sleepExec,
	input wire logic twoSpeedCfg,
	input wire logic failMonCfg,
	input wire logic sysClkExternal,
	input wire logic sysClkHoldLow,
	input wire logic execHold,
	input wire logic startupTimeout,
	input wire logic failSafeActive,
	input wire logic oscFailIrq,
	input wire logic [2:0] intFreqSelect
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// source status and switchover
	a_reset_freq: assert property ($rose(rst_n) |-> intFreqSelect == 3'h6)
		else $error("frequency select not at reset value");
	a_freq_write: assert property (wrStrobe && addr == 3'h0 |=> intFreqSelect == $past(wrData[6:4]))
		else $error("frequency select missed a write");
	a_ext_timeout: assert property (sysClkExternal |-> startupTimeout)
		else $error("external clock without timeout status");
	a_hold_gap: assert property (sysClkHoldLow |-> startupTimeout && !sysClkExternal)
		else $error("hold-low gap overlaps external clock");
	a_exec_twospeed: assert property (execHold [*4] |-> !(twoSpeedCfg || failMonCfg))
		else $error("execution held during two-speed start-up");

	////////////////////////////////////////////////////////////////////////////////
	// fail-safe monitor
	a_fail_needs_mon: assert property ($rose(failSafeActive) |-> failMonCfg)
		else $error("failure flagged with monitor off");
	a_fail_internal: assert property ($rose(failSafeActive) |-> !sysClkExternal && !startupTimeout)
		else $error("failure did not fall back to internal");
	a_irq_cause: assert property ($rose(oscFailIrq) |-> failSafeActive || $past(wrStrobe))
		else $error("fail interrupt without cause");
	a_sleep_clears: assert property (sleepExec |=> !failSafeActive && !startupTimeout)
		else $error("sleep left fail-safe or timeout set");
endmodule // csf_clock_startup_failsafe_asserts

bind csf_clock_startup_failsafe csf_clock_startup_failsafe_asserts i_asserts (
	.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
	.sleepExec(sleepExec), .twoSpeedCfg(twoSpeedCfg), .failMonCfg(failMonCfg),
	.sysClkExternal(sysClkExternal), .sysClkHoldLow(sysClkHoldLow), .execHold(execHold),
	.startupTimeout(startupTimeout), .failSafeActive(failSafeActive),
	.oscFailIrq(oscFailIrq), .intFreqSelect(intFreqSelect)
);

/* verification/csf_ext_osc.sv */
// external crystal or clock source seen as a level sampled on clk
// assumes halfPeriod of at least one clk cycle
`timescale 1ns/10ps
module csf_ext_osc (
	input wire logic clk,
	input wire logic run,
	input wire logic [3:0] halfPeriod,
	output logic oscOut
);
	logic [3:0] cnt;

	// a stalled source sticks high, so the monitor never sees it go low
	always_ff @(posedge clk) begin
		if (!run) begin
			cnt <= 4'h0;
			oscOut <= 1'b1;
		end else if (cnt + 4'h1 >= halfPeriod) begin
			cnt <= 4'h0;
			oscOut <= ~oscOut;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule // csf_ext_osc

/* verification/clock_startup_failsafe_test.sv */
// self-checking bench for the clock start-up / fail-safe block
// assumes straps change only under reset; power-up timer left off
`timescale 1ns/10ps
module clock_startup_failsafe_test;
	logic clk = 0, rst_n = 0, wrStrobe = 0, rdStrobe = 0, extRun = 0;
	logic [2:0] addr = 0, oscModeCfg = 0, tick = 0;
	logic [7:0] wrData = 0, rdData, v;
	logic [3:0] extHalf = 2;
	logic twoSpeedCfg = 0, failMonCfg = 0, sleepExec = 0, wakeEvent = 0;
	logic extClkIn, sysClkExternal, sysClkHoldLow, execHold, startupTimeout;
	logic failSafeActive, oscFailIrq;
	logic [2:0] intFreqSelect;
	logic [4:0] oscTuning;
	int miscompares = 0, check_count = 0, n, h;
	int mFreq, mTune, mIrqEn, mFlag, mSel;

	////////////////////////////////////////////////////////////////////////////////
	// clock, internal oscillators (lf rises every 8 clk), far side
	always #10 clk = ~clk;
	always @(posedge clk) tick <= tick + 3'h1;
	csf_ext_osc i_osc (.clk(clk), .run(extRun), .halfPeriod(extHalf), .oscOut(extClkIn));
	csf_clock_startup_failsafe i_dut (
		.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .extClkIn(extClkIn), .intOscIn(tick[1]),
		.lfOscIn(tick[2]), .oscModeCfg(oscModeCfg), .twoSpeedCfg(twoSpeedCfg),
		.failMonCfg(failMonCfg), .powerupTimerCfg(1'b0), .powerupTimerDone(1'b0),
		.sleepExec(sleepExec), .wakeEvent(wakeEvent), .sysClkExternal(sysClkExternal),
		.sysClkHoldLow(sysClkHoldLow), .execHold(execHold), .startupTimeout(startupTimeout),
		.failSafeActive(failSafeActive), .oscFailIrq(oscFailIrq),
		.intFreqSelect(intFreqSelect), .oscTuning(oscTuning)
	);

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// source held stopped under reset so the model starts from a known level
	task boot(input logic [2:0] m, input logic ts, input logic fm);
		@(posedge clk);
		rst_n <= 0;
		oscModeCfg <= m;
		twoSpeedCfg <= ts;
		failMonCfg <= fm;
		extRun <= 0;
		repeat (8) @(posedge clk);
		rst_n <= 1;
		extRun <= 1;
		{mFreq, mTune, mIrqEn, mFlag, mSel} = {32'd6, 32'd0, 32'd0, 32'd0, 32'd0};
		repeat (3) @(posedge clk);
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1;
		@(posedge clk);
		wrStrobe <= 0;
	endtask
	task rd(input logic [2:0] a);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1;
		@(posedge clk);
		rdStrobe <= 0;
		#1 v = rdData;
	endtask
	// waits on fail-safe (sel 1) or external clock (sel 0), bounded
	task waitOn(input int sel, input int lim);
		n = 0;
		while ((sel ? failSafeActive : sysClkExternal) !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	function logic [7:0] ctlExp(input int t, input int fm);
		return {1'b0, mFreq[2:0], t[0], mFreq != 0, mFreq == 0 || fm != 0, mSel[0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// watchdog well past the ~20k cycles the sequence needs
	initial begin
		#(60000 * 20);
		miscompares++;
		end_of_test;
	end

	initial begin
		void'($urandom(32'hB848B4EF));
		// crystal two-speed: internal until 1024 external falls counted
		boot(3'h1, 1, 0);
		rd(3'h0);
		chk(v, ctlExp(0, 0));
		chk(execHold, 0);
		chk(sysClkExternal, 0);
		waitOn(0, 9000);
		chk(n >= 4 * 1020, 1);
		chk(startupTimeout, 1);
		// crystal without two-speed: execution held, source half period random from 1 to 3 clk
		h = $urandom_range(1, 3);
		extHalf <= h[3:0];
		boot(3'h2, 0, 0);
		chk(execHold, 1);
		waitOn(0, 2 * h * 1024 + 300);
		chk(n >= 2 * h * 1020, 1);
		chk(execHold, 0);
		chk(sysClkExternal, 1);
		extHalf <= 2;
		// sleep mid start-up aborts; wake restarts two-speed
		boot(3'h0, 1, 0);
		@(posedge clk);
		sleepExec <= 1;
		@(posedge clk);
		sleepExec <= 0;
		repeat (4500) @(posedge clk);
		chk(startupTimeout, 0);
		wakeEvent <= 1;
		@(posedge clk);
		wakeEvent <= 0;
		waitOn(0, 5000);
		chk(startupTimeout, 1);
		// external clock mode with monitor: no timer, then failure
		boot(3'h3, 1, 1);
		waitOn(0, 5);
		chk(sysClkExternal, 1);
		rd(3'h5);
		chk(v, 8'h00);
		mTune = $urandom;
		wr(3'h1, mTune[7:0]);
		rd(3'h1);
		chk(v, {3'h0, mTune[4:0]});
		chk(oscTuning, mTune[4:0]);
		wr(3'h4, 8'hFF);
		rd(3'h4);
		chk(v, 8'hC3);
		mFreq = $urandom_range(1, 7);
		wr(3'h0, {1'b0, mFreq[2:0], 4'h0});
		wr(3'h2, 8'h80);
		mIrqEn = 1;
		extRun <= 0;
		waitOn(1, 1000);
		chk(n >= 240, 1);
		chk(failSafeActive, 1);
		chk(sysClkExternal, 0);
		mFlag = 1;
		chk(oscFailIrq, mFlag & mIrqEn);
		chk(intFreqSelect, mFreq);
		rd(3'h0);
		chk(v, ctlExp(0, 1));
		repeat (600) @(posedge clk);
		chk(sysClkExternal, 0);
		wr(3'h3, 8'h00);
		rd(3'h3);
		chk(v, 8'h80);
		extRun <= 1;
		mSel = 1;
		wr(3'h0, {1'b0, mFreq[2:0], 4'h1});
		repeat (3) @(posedge clk);
		#1 chk(failSafeActive, 0);
		chk(sysClkExternal, 1);
		wr(3'h3, 8'h00);
		mFlag = 0;
		rd(3'h3);
		chk(v, {mFlag[0], 7'h00});
		chk(oscFailIrq, 0);
		end_of_test;
	end
endmodule // clock_startup_failsafe_test
